/* dpw_top.sv */
// serial control port of a single-channel digital potentiometer
`include "dpw_consts.svh"
module dpw_top
	import dpw_pkg::*;
(
	// clock and reset
	input  wire logic       CLK_SYS_IN,
	input  wire logic       RESET_IN,
	// serial pins
	input  wire logic       SCLK_IN,
	input  wire logic       SYNC_N_IN,
	input  wire logic       DIN_IN,
	input  wire logic       HW_RESET_IN,
	output logic            SERIAL_OUT_OD_OUT,
	output logic            SERIAL_OUT_OD_OE_OUT,
	output logic            READY_OD_OUT,
	output logic            READY_OD_OE_OUT,
	// wiper state
	output logic [9:0]      WIPER_POSITION_OUT
);
	dpw_sync_if sy ();

	dpw_pin_sync u_sync (
		.clk_in      (CLK_SYS_IN),
		.rst_in      (RESET_IN),
		.sclk_in     (SCLK_IN),
		.sync_n_in   (SYNC_N_IN),
		.din_in      (DIN_IN),
		.hw_reset_in (HW_RESET_IN),
		.sy          (sy.src)
	);

	localparam logic [7:0] EXEC_CYC = 8'(`DPW_EXEC_CYCLES);

	dpw_word_t                   shift_reg, shift_next;
	logic [`DPW_CNT_BITS-1:0]    cnt_reg;
	logic                        full_reg;
	dpw_wiper_t                  wiper_position_reg, wiper_next;
	logic                        wiper_write_enable_bit;
	logic                        we_next;
	dpw_state_e                  state_reg, state_next;
	logic [7:0]                  exec_reg;
	logic                        serial_oe_reg;
	logic                        cmd_read_pending;
	logic                        rdy_low_reg;

	// decode of a completed frame
	wire        shift_en   = sy.sync_low & sy.sclk_fall;
	wire [3:0]  cmd        = shift_reg[`DPW_CMD_MSB:`DPW_CMD_LSB];
	wire [9:0]  data       = shift_reg[`DPW_DATA_MSB:`DPW_DATA_LSB];
	wire        frame_ok   = sy.sync_rise & full_reg & (cnt_reg == 4'h0);
	wire        do_write   = frame_ok & (cmd == `DPW_CMD_WRITE) & wiper_write_enable_bit;
	wire        do_read    = frame_ok & (cmd == `DPW_CMD_READ);
	wire        do_swrst   = frame_ok & (cmd == `DPW_CMD_SWRESET);
	wire        do_ctrl    = frame_ok & (cmd == `DPW_CMD_CTRL);
	wire        exec_start = do_write | do_read;
	wire        exec_done  = (state_reg == DPW_EXEC) & (exec_reg == 8'h01);

	always_comb begin
		shift_next = shift_reg;
		if (shift_en)
			shift_next = {shift_reg[14:0], sy.din};
		else if (exec_done && cmd_read_pending)
			shift_next = {6'h00, wiper_position_reg};
	end

	always_comb begin
		wiper_next = wiper_position_reg;
		if (sy.rst_rise || do_swrst)
			wiper_next = `DPW_WIPER_MID;
		else if (do_write)
			wiper_next = data;
	end

	assign we_next = do_ctrl ? data[`DPW_CTRL_WE_POS] : wiper_write_enable_bit;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DPW_IDLE: if (exec_start) state_next = DPW_EXEC;
			DPW_EXEC: if (exec_done)  state_next = DPW_IDLE;
			default:  state_next = DPW_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			shift_reg              <= 16'h0000;
			cnt_reg                <= 4'h0;
			full_reg               <= 1'b0;
			wiper_position_reg     <= `DPW_WIPER_MID;
			wiper_write_enable_bit <= 1'b0;
		end else begin
			shift_reg              <= shift_next;
			wiper_position_reg     <= wiper_next;
			wiper_write_enable_bit <= we_next;
			if (sy.sync_fall || sy.sync_rise) begin
				cnt_reg  <= 4'h0;
				full_reg <= 1'b0;
			end else if (shift_en) begin
				cnt_reg  <= cnt_reg + 4'h1;
				if (cnt_reg == 4'hF)
					full_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			state_reg        <= DPW_IDLE;
			exec_reg         <= 8'h00;
			cmd_read_pending <= 1'b0;
			rdy_low_reg      <= 1'b0;
			serial_oe_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (exec_start) begin
				exec_reg         <= EXEC_CYC;
				cmd_read_pending <= do_read;
			end else if (exec_reg != 8'h00) begin
				exec_reg <= exec_reg - 8'h01;
			end
			rdy_low_reg <= (state_next == DPW_EXEC);
			serial_oe_reg <= ~shift_next[15];
		end
	end

	// open-drain pins: drive low only
	assign SERIAL_OUT_OD_OUT    = 1'b0;
	assign SERIAL_OUT_OD_OE_OUT = serial_oe_reg;
	assign READY_OD_OUT         = 1'b0;
	assign READY_OD_OE_OUT      = rdy_low_reg;
	assign WIPER_POSITION_OUT   = wiper_position_reg;
endmodule : dpw_top

/* dpw_consts.svh */
// constants for the digipot serial wiper port
`ifndef DPW_CONSTS_SVH
`define DPW_CONSTS_SVH
`define DPW_WORD_BITS      16
`define DPW_CNT_BITS       4
`define DPW_CMD_MSB        13
`define DPW_CMD_LSB        10
`define DPW_DATA_MSB       9
`define DPW_DATA_LSB       0
`define DPW_WIPER_MID      10'h200
`define DPW_CMD_NOP        4'h0
`define DPW_CMD_WRITE      4'h1
`define DPW_CMD_READ       4'h2
`define DPW_CMD_SWRESET    4'h4
`define DPW_CMD_CTRL       4'h6
`define DPW_CTRL_WE_POS    1
`define DPW_EXEC_NS        40
`define DPW_CLK_PERIOD_NS  5
`define DPW_EXEC_CYCLES    ((`DPW_EXEC_NS + `DPW_CLK_PERIOD_NS - 1) / `DPW_CLK_PERIOD_NS)
`endif

/* dpw_pkg.sv */
// types for the digipot serial wiper port
package dpw_pkg;
	typedef logic [9:0]  dpw_wiper_t;
	typedef logic [15:0] dpw_word_t;
	typedef enum logic [1:0] {
		DPW_IDLE = 2'b00,
		DPW_EXEC = 2'b01
	} dpw_state_e;
endpackage : dpw_pkg

/* dpw_sync_if.sv */
// synchronised pin levels and edge strobes passed between modules
interface dpw_sync_if;
	logic sclk_fall;
	logic sync_fall;
	logic sync_rise;
	logic sync_low;
	logic din;
	logic rst_rise;
	modport src (output sclk_fall, sync_fall, sync_rise, sync_low, din, rst_rise);
	modport dst (input  sclk_fall, sync_fall, sync_rise, sync_low, din, rst_rise);
endinterface : dpw_sync_if

/* dpw_pin_sync.sv */
// two-flop synchronisers and edge detection for the serial pins
module dpw_pin_sync (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic sclk_in,
	input  wire logic sync_n_in,
	input  wire logic din_in,
	input  wire logic hw_reset_in,
	dpw_sync_if.src   sy
);
	logic [3:0] meta_reg;
	logic [3:0] stab_reg;
	logic [3:0] prev_reg;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_reg <= 4'hF;
			stab_reg <= 4'hF;
			prev_reg <= 4'hF;
		end else begin
			meta_reg <= {hw_reset_in, din_in, sync_n_in, sclk_in};
			stab_reg <= meta_reg;
			prev_reg <= stab_reg;
		end
	end

	assign sy.sclk_fall = prev_reg[0] & ~stab_reg[0];
	assign sy.sync_fall = prev_reg[1] & ~stab_reg[1];
	assign sy.sync_rise = ~prev_reg[1] & stab_reg[1];
	assign sy.sync_low  = ~stab_reg[1];
	assign sy.din       = stab_reg[2];
	assign sy.rst_rise  = ~prev_reg[3] & stab_reg[3];
endmodule : dpw_pin_sync

/* dpw_master.sv */
// serial master model driving frames into the wiper port
module dpw_master (
	// serial lines
	output logic      sclk_out,
	output logic      sync_n_out,
	output logic      din_out,
	input  wire logic ser_line_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] rd;
	initial begin
		sclk_out = 1'b1;
		sync_n_out = 1'b1;
		din_out = 1'b0;
	end
	// n bits msb first; serial out taken just before each fall
	task automatic frame(input logic [31:0] w, input int n);
		sync_n_out = 1'b0;
		#20;
		for (int i = n - 1; i >= 0; i--) begin
			din_out = w[i];
			#24 rd = {rd[14:0], ser_line_in};
			sclk_out = 1'b0;
			#24 sclk_out = 1'b1;
		end
		#20 sync_n_out = 1'b1;
		din_out = ~din_out;
	endtask : frame
endmodule : dpw_master

/* dpw_checker.sv */
// port checker for the digipot serial wiper port
module dpw_checker (
	// clock and reset
	input wire logic       CLK_SYS_IN,
	input wire logic       RESET_IN,
	// watched pins
	input wire logic       SYNC_N_IN,
	input wire logic       HW_RESET_IN,
	input wire logic       SERIAL_OUT_OD_OUT,
	input wire logic       SERIAL_OUT_OD_OE_OUT,
	input wire logic       READY_OD_OUT,
	input wire logic       READY_OD_OE_OUT,
	input wire logic [9:0] WIPER_POSITION_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (RESET_IN);
	ser_drain_a: assert property (!SERIAL_OUT_OD_OUT) else $error("serial out high");
	rdy_drain_a: assert property (!READY_OD_OUT) else $error("rdy high");
	rst_mid_a: assert property ($fell(RESET_IN) |->
		WIPER_POSITION_OUT == 10'h200 && !READY_OD_OE_OUT) else $error("bad reset");
	hw_mid_a: assert property ($rose(HW_RESET_IN) |->
		##[2:8] WIPER_POSITION_OUT == 10'h200) else $error("no hw midscale");
	busy_len_a: assert property ($rose(READY_OD_OE_OUT) |->
		READY_OD_OE_OUT [*8] ##1 !READY_OD_OE_OUT) else $error("busy length");
	busy_cause_a: assert property ($rose(READY_OD_OE_OUT) |->
		SYNC_N_IN && $past(SYNC_N_IN, 3)) else $error("busy without frame end");
	frame_hold_a: assert property (!SYNC_N_IN [*4] |->
		$stable(WIPER_POSITION_OUT)) else $error("wiper moved in frame");
	wiper_when_a: assert property (!$stable(WIPER_POSITION_OUT) |->
		SYNC_N_IN) else $error("wiper moved with frame open");
	cover property ($rose(READY_OD_OE_OUT));
	cover property ($rose(HW_RESET_IN));
	cover property ($fell(SERIAL_OUT_OD_OE_OUT));
endmodule : dpw_checker
bind dpw_top dpw_checker dpw_checker_i (.*);

/* tb.sv */
// self-checking bench for the digipot serial wiper port
module tb import dpw_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hw = 1'b0;
	logic        sclk, sync_n, din, ser_v, ser_oe, rdy_v, rdy_oe, bsy;
	dpw_wiper_t  wiper;
	dpw_word_t   lfsr = 16'h10FB;
	logic [17:0] exp_q[$];
	int          fail_count = 0;
	int          samples_checked = 0;
	event        done_ev;
	always #2.5 clk = ~clk;
	dpw_top dpw_top_i (.CLK_SYS_IN(clk), .RESET_IN(rst), .SCLK_IN(sclk), .SYNC_N_IN(sync_n),
		.DIN_IN(din), .HW_RESET_IN(hw), .SERIAL_OUT_OD_OUT(ser_v),
		.SERIAL_OUT_OD_OE_OUT(ser_oe), .READY_OD_OUT(rdy_v), .READY_OD_OE_OUT(rdy_oe),
		.WIPER_POSITION_OUT(wiper));
	dpw_master dpw_master_i (.sclk_out(sclk), .sync_n_out(sync_n), .din_out(din),
		.ser_line_in(ser_oe ? ser_v : 1'b1));
	function automatic logic [31:0] wd(input logic [3:0] c, input dpw_wiper_t d);
		return {18'h00000, c, d};
	endfunction : wd
	task automatic check(input string what, input dpw_word_t seen, input dpw_word_t exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// watch for busy while the port settles, then hand over the note
	task automatic note(input logic [17:0] e);
		bsy = 1'b0;
		repeat (20) @(negedge clk) bsy |= rdy_oe;
		exp_q.push_back(e);
		-> done_ev;
	endtask : note
	task automatic send(input logic [31:0] w, input int n, input logic [17:0] e);
		@(negedge clk);
		dpw_master_i.frame(w, n);
		note(e);
	endtask : send
	always @(done_ev) begin : monitor
		logic [17:0] e;
		e = exp_q.pop_front();
		check("wiper", e[16] ? dpw_master_i.rd : {6'h00, wiper}, e[15:0]);
		check("busy", {15'h0000, bsy}, {15'h0000, e[17]});
	end
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		repeat (6) @(negedge clk);
		send(wd(4'h1, 10'h155), 16, 18'h00200);
		send(wd(4'h6, 10'h002), 16, 18'h00200);
		repeat (3) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			send(wd(4'h1, lfsr[9:0]), 16, {8'h80, lfsr[9:0]});
		end
		send(wd(4'h1, 10'h0F0) >> 6, 10, {8'h00, lfsr[9:0]});
		send((wd(4'h1, 10'h3FF) << 16) | wd(4'h1, 10'h0AA), 32, 18'h200AA);
		send(wd(4'h2, 10'h000), 16, 18'h200AA);
		send(32'h00000000, 16, 18'h100AA);
		send(wd(4'h4, 10'h000), 16, 18'h00200);
		send(wd(4'h1, 10'h3FF), 16, 18'h203FF);
		@(negedge clk) hw = 1'b1;
		note(18'h00200);
		@(negedge clk);
		end_of_test();
	end
	initial begin
		#100us;
		fail_count++;
		end_of_test();
	end
endmodule : tb
